// ### rtl/rtci_pkg.sv
/*
  Shared constants for the clock control and interrupt timer block:
  register addresses, control bit positions, period codes and counts.
  Assumes a 200 MHz reference clock and a 4-bit parallel register port.
*/
package rtci_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SHARED = 4'hF;
  localparam int BIT_TEST = 3;
  localparam int BIT_CLK_HALT = 2;
  localparam int BIT_INT_SEL = 1;
  localparam int BIT_INT_HALT = 0;
  localparam int BIT_REPEAT = 3;
  localparam logic [3:0] CTRL_RESET = 4'hF;
  localparam logic [3:0] INT_WORD_RESET = 4'h0;
  localparam logic [3:0] CLK_SET_RESET = 4'h0;
  // Timing: 200 MHz reference, 0.1 s base tick for the timer
  localparam int CLK_HZ = 200000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Oscillator emulation: 32768 Hz from the reference via half period
  localparam int OSC_HZ = 32768;
  localparam int OSC_HALF_CYCLES = CLK_HZ / (2 * OSC_HZ);
  // Tenths per period code 1..7: 1,5,10,50,100,300,600
  localparam logic [9:0] PERIOD_TENTHS [8] = '{10'h000, 10'h001, 10'h005,
    10'h00A, 10'h032, 10'h064, 10'h12C, 10'h258};
endpackage

// ### rtl/rtci_divider.sv
/*
  Enable pulse generator dividing the reference clock.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module rtci_divider #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  output logic tick
);
  // Elaboration check: a divide by one would never pulse low
  if (DIV < 2) begin : g_bad_div
    $error("rtci_divider: DIV must be at least 2");
  end
  logic [31:0] count;
  wire at_end = (count == 32'(DIV - 1));
  // Clear restarts the phase so a new start gives a full period
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count <= 32'h00000000;
    end else if (at_end) begin
      count <= 32'h00000000;
    end else begin
      count <= count + 32'h00000001;
    end
  end
  // Pulse one cycle at the end of each division
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      tick <= 1'b0;
    end else begin
      tick <= at_end;
    end
  end
endmodule

// ### rtl/rtci_top.sv
/*
  Control register, time rollover flag, test mode oscillator output and
  the programmable interrupt timer of a real time clock.
  Assumes bus strobes already synchronous to REF_CLK, and a clock setting
  pulse supplied by the time counters outside this block.
*/
`timescale 1ns/1ps
module rtci_top #(
  parameter int TICK_DIV = rtci_pkg::TICK_CYCLES,
  parameter int OSC_HALF = rtci_pkg::OSC_HALF_CYCLES
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [3:0] ADDR,
  input wire logic [3:0] WDATA,
  output logic [3:0] RDATA,
  output logic RDATA_VALID,
  // Time counter side
  input wire logic CLOCK_SET_PULSE,
  output logic CLOCK_HALT,
  output logic TEST_MODE,
  output logic FAST_CLOCK_EN,
  output logic [3:0] CLOCK_SETTING,
  // Interrupt pin: level, enable active low
  output logic INT_OUT,
  output logic INT_OE_N
);
  import rtci_pkg::*;

  // Elaboration check: both dividers need a count of at least two
  if (TICK_DIV < 2 || OSC_HALF < 2) begin : g_bad_counts
    $error("rtci_top: divider counts too small");
  end

  logic [3:0] ctrl;
  logic [3:0] int_word;
  logic time_rollover_flag;
  logic int_flag;
  logic int_pending;
  logic [9:0] tenths;
  logic timer_done;
  logic osc;
  logic [31:0] osc_count;
  logic rd_q;
  logic fast_q;

  // Strobe decode
  wire acc = !CS_N;
  wire rd_now = acc && !RD_N;
  wire wr_ctrl = acc && !WR_N && ADDR == ADDR_CTRL;
  wire wr_shared = acc && !WR_N && ADDR == ADDR_SHARED;
  wire address_zero_select = rd_now && ADDR == ADDR_CTRL;
  // Trailing edge of a control read clears the flags
  wire ctrl_rd_end = rd_q && !address_zero_select;
  wire wr_int = wr_shared && ctrl[BIT_INT_SEL];
  wire wr_clk = wr_shared && !ctrl[BIT_INT_SEL];
  wire period_zero = int_word[2:0] == 3'b000;
  wire repeat_mode = int_word[BIT_REPEAT];
  wire timer_run = !ctrl[BIT_INT_HALT] && !timer_done;
  wire start_write = wr_ctrl && !WDATA[BIT_INT_HALT];
  wire timer_clear = !timer_run || start_write;
  wire [9:0] limit = PERIOD_TENTHS[int_word[2:0]];
  wire tick;
  wire timeout = timer_run && tick && (tenths + 10'h001 == limit);
  wire osc_gate = ctrl[BIT_TEST] && period_zero;
  wire osc_flip = osc_count == 32'(OSC_HALF - 1);

  // Base 0.1 s tick, restarted by any stop or start of the timer
  rtci_divider #(.DIV(TICK_DIV)) u_tick (
    .clk(REF_CLK),
    .rst(RST),
    .clear(timer_clear),
    .tick(tick)
  );

  // Control latches; empty interrupt word forces the timer halted
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= WDATA;
      if (period_zero) begin
        ctrl[BIT_INT_HALT] <= 1'b1;
      end
    end else if (wr_int && WDATA[2:0] == 3'b000) begin
      ctrl[BIT_INT_HALT] <= 1'b1;
    end
  end

  // Interrupt word and clock setting register share address 15
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      int_word <= INT_WORD_RESET;
      CLOCK_SETTING <= CLK_SET_RESET;
    end else begin
      if (wr_int) begin
        int_word <= WDATA;
      end
      if (wr_clk) begin
        CLOCK_SETTING <= WDATA;
      end
    end
  end

  // Timer: counts tenths; single mode stops after one timeout
  always_ff @(posedge REF_CLK) begin
    if (RST || timer_clear) begin
      tenths <= 10'h000;
    end else if (tick) begin
      tenths <= timeout ? 10'h000 : tenths + 10'h001;
    end
  end

  // Done latch holds a single shot until the next start write or an interrupt halt
  always_ff @(posedge REF_CLK) begin
    if (RST || start_write || ctrl[BIT_INT_HALT]) begin
      timer_done <= 1'b0;
    end else if (timeout && !repeat_mode) begin
      timer_done <= 1'b1;
    end
  end

  // Read strobe history and captured status during a control read
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_q <= 1'b0;
      RDATA <= 4'h0;
      RDATA_VALID <= 1'b0;
    end else begin
      rd_q <= address_zero_select;
      RDATA_VALID <= rd_now;
      if (address_zero_select && !rd_q) begin
        RDATA <= {time_rollover_flag, 2'b00, int_flag};
      end else if (rd_now && ADDR == ADDR_SHARED) begin
        RDATA <= ctrl[BIT_INT_SEL] ? int_word : CLOCK_SETTING;
      end else if (!address_zero_select) begin
        RDATA <= 4'h0;
      end
    end
  end

  // Rollover flag: clear wins over set; pulses during a control read and in its end cycle are dropped
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      time_rollover_flag <= 1'b0;
    end else if (CLOCK_SET_PULSE && !address_zero_select && !rd_q) begin
      time_rollover_flag <= 1'b1;
    end else if (ctrl_rd_end) begin
      time_rollover_flag <= 1'b0;
    end
  end

  // Timeout during a control read is held pending and shown after that read
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      int_flag <= 1'b0;
      int_pending <= 1'b0;
    end else if (address_zero_select || rd_q) begin
      if (timeout) begin
        int_pending <= 1'b1;
      end
      if (ctrl_rd_end) begin
        int_flag <= int_pending || timeout;
        int_pending <= 1'b0;
      end
    end else if (timeout) begin
      int_flag <= 1'b1;
    end
  end

  // Emulated 32.768 kHz oscillator for test mode trimming
  always_ff @(posedge REF_CLK) begin
    if (RST || osc_flip) begin
      osc_count <= 32'h00000000;
    end else begin
      osc_count <= osc_count + 32'h00000001;
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      osc <= 1'b0;
    end else if (osc_flip) begin
      osc <= !osc;
    end
  end

  // Interrupt pin: driven oscillator in test with period code 0, else open drain low
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      INT_OUT <= 1'b0;
      INT_OE_N <= 1'b1;
    end else if (osc_gate) begin
      INT_OUT <= osc;
      INT_OE_N <= 1'b0;
    end else begin
      INT_OUT <= 1'b0;
      INT_OE_N <= !int_flag;
    end
  end

  // Time counter controls; fast clocking only while not halted
  assign fast_q = osc_flip && osc && !ctrl[BIT_CLK_HALT];
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      CLOCK_HALT <= 1'b1;
      TEST_MODE <= 1'b1;
      FAST_CLOCK_EN <= 1'b0;
    end else begin
      CLOCK_HALT <= ctrl[BIT_CLK_HALT];
      TEST_MODE <= ctrl[BIT_TEST];
      FAST_CLOCK_EN <= ctrl[BIT_TEST] && fast_q;
    end
  end
endmodule

// ### dv/rtci_chk.sv
/* Port checker for rtci_top.
   Assumes it is bound into rtci_top and sees only its ports. */
`timescale 1ns/1ps
module rtci_chk (
  // Clock, reset and bus
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [3:0] ADDR,
  input wire logic [3:0] WDATA,
  input wire logic [3:0] RDATA,
  input wire logic RDATA_VALID,
  // Watched outputs
  input wire logic CLOCK_HALT,
  input wire logic TEST_MODE,
  input wire logic FAST_CLOCK_EN,
  input wire logic INT_OUT,
  input wire logic INT_OE_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Decode; the end of a control read is what clears the flags
  logic in_rd;
  wire rd_ctl = !CS_N && !RD_N && ADDR == 4'h0;
  wire wr_ctl = !CS_N && !WR_N && ADDR == 4'h0;
  wire rd_odd = !CS_N && !RD_N && ADDR != 4'h0 && ADDR != 4'hF;
  always_ff @(posedge REF_CLK) in_rd <= rd_ctl;
  AST_VALID: assert property (!CS_N && !RD_N |=> RDATA_VALID)
    else $error("read not answered");
  // Control latch, then the output flop: two edges from write to pin
  AST_HALT: assert property (
    wr_ctl |-> ##2 CLOCK_HALT == $past(WDATA[2], 2))
    else $error("clock halt bit not taken");
  AST_TEST: assert property (
    wr_ctl |-> ##2 TEST_MODE == $past(WDATA[3], 2))
    else $error("test bit not taken");
  AST_ZERO: assert property (rd_ctl |=> RDATA[2:1] == 2'h0)
    else $error("control read middle bits set");
  AST_ODD: assert property (rd_odd |=> RDATA == 4'h0)
    else $error("unmapped read not zero");
  AST_FAST: assert property (
    (!TEST_MODE || CLOCK_HALT) [*2] |-> !FAST_CLOCK_EN)
    else $error("fast clock while gated");
  AST_OSC: assert property (!TEST_MODE [*2] |-> !INT_OUT)
    else $error("oscillator out of test mode");
  AST_CLR: assert property (
    in_rd && !rd_ctl && !TEST_MODE |-> ##[2:3] INT_OE_N)
    else $error("pin not released after read");
  // Main scenarios
  cover property (in_rd && RDATA[0]);
  cover property (FAST_CLOCK_EN);
  cover property ($fell(INT_OE_N) && !TEST_MODE);
endmodule
bind rtci_top rtci_chk u_chk (.REF_CLK(REF_CLK), .RST(RST),
  .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR), .WDATA(WDATA),
  .RDATA(RDATA), .RDATA_VALID(RDATA_VALID), .CLOCK_HALT(CLOCK_HALT),
  .TEST_MODE(TEST_MODE), .FAST_CLOCK_EN(FAST_CLOCK_EN),
  .INT_OUT(INT_OUT), .INT_OE_N(INT_OE_N));

// ### dv/rtci_host.sv
/* Host processor model on the register port.
   Assumes the bench calls wr and rd; bus moves on falling edges. */
`timescale 1ns/1ps
module rtci_host (
  // Clock and answer
  input wire logic clk,
  input wire logic [3:0] rdata,
  // Bus to the device
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] addr,
  output logic [3:0] wdata
);
  // Idle bus; released lines show the inverse so stale values never pass
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 4'h0;
    wdata = 4'h0;
  end
  // One-cycle write strobe; a longer one only repeats the write
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    wdata = d;
    @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    addr = ~a;
    wdata = ~d;
  endtask
  // Short strobe; the flags clear as soon as it ends
  task automatic rd(input logic [3:0] a, output logic [3:0] q);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    @(negedge clk);
    q = rdata;
    cs_n = 1'b1;
    rd_n = 1'b1;
    addr = ~a;
  endtask
endmodule

// ### dv/test_rtci_top.sv
/* Self-checking bench for rtci_top driven through a host model.
   Assumes the short timer and oscillator counts set below. */
`timescale 1ns/1ps
module test_rtci_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic csp = 1'b0;
  logic cs_n, rd_n, wr_n, int_out, oe_n, fce, halt, tm, prev;
  logic [3:0] addr, wdata, rdata, cset, q;
  int error_cnt = 0;
  int n_checks = 0;
  int n, tg, fc;
  int per [8] = '{0, 1, 5, 10, 50, 100, 300, 600};
  always #2.5 clk = ~clk;
  rtci_top #(.TICK_DIV(20), .OSC_HALF(4)) uut (.REF_CLK(clk), .RST(rst),
    .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr), .WDATA(wdata),
    .RDATA(rdata), .RDATA_VALID(), .CLOCK_SET_PULSE(csp),
    .CLOCK_HALT(halt), .TEST_MODE(tm), .FAST_CLOCK_EN(fce),
    .CLOCK_SETTING(cset), .INT_OUT(int_out), .INT_OE_N(oe_n));
  rtci_host h (.clk(clk), .rdata(rdata), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .wdata(wdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait for the pin to be pulled low
  task automatic wait_int(input int lim);
    n = 0;
    while (oe_n !== 1'b0 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // Pin toggles and fast clock pulses over 16 settled cycles
  task automatic count16;
    tg = 0;
    fc = 0;
    repeat (2) @(negedge clk);
    repeat (16) begin
      prev = int_out;
      @(negedge clk);
      tg += (int_out != prev);
      fc += fce;
    end
  endtask
  task automatic t_init;
    h.wr(4'h0, 4'hF);
    h.wr(4'hF, 4'h0);
    count16;
    chk({tm, halt, oe_n, tg[3:0], fc[3:0]}, 11'h640);
    h.wr(4'h0, 4'h8);
    count16;
    chk(fc != 0, 1);
    h.wr(4'h0, 4'hF);
    h.wr(4'hF, 4'h1);
    count16;
    chk(tg + int_out, 0);
    h.wr(4'hF, 4'h0);
  endtask
  task automatic t_clock;
    h.wr(4'h0, 4'h5);
    @(negedge clk);
    chk({tm, halt}, 2'b01);
    h.wr(4'hF, 4'h1);
    h.wr(4'hF, 4'h5);
    h.rd(4'hF, q);
    chk({cset, q}, 8'h55);
    h.wr(4'h0, 4'h0);
    @(negedge clk);
    chk(halt, 0);
  endtask
  // Pulse, then a write and other reads must leave the flag set
  task automatic t_flag;
    h.rd(4'h0, q);
    @(negedge clk);
    csp = 1'b1;
    @(negedge clk);
    csp = 1'b0;
    h.wr(4'h0, 4'h0);
    h.rd(4'hF, q);
    h.rd(4'h5, q);
    chk(q, 0);
    h.rd(4'h0, q);
    chk(q, 4'h8);
    h.rd(4'h0, q);
    chk(q, 0);
  endtask
  task automatic t_int(input logic [3:0] w, st, input int lim);
    h.wr(4'h0, 4'h3);
    @(negedge clk);
    chk(halt, 0);
    h.wr(4'hF, w);
    h.wr(4'h0, st);
    wait_int(lim);
  endtask
  // Control read acknowledges; the pin lets go
  task automatic ack;
    h.rd(4'h0, q);
    repeat (3) @(negedge clk);
    chk({q[0], oe_n}, 2'b11);
  endtask
  task automatic t_codes;
    for (int c = 1; c < 8; c++) begin
      t_int(4'(c), c[0] ? 4'h2 : 4'h0, 13000);
      chk(n >= 20 * per[c] && n <= 20 * per[c] + 6, 1);
      ack;
    end
    wait_int(100);
    chk(n, 100);
    t_int(4'h8, 4'h0, 100);
    chk(n, 100);
  endtask
  task automatic t_rep;
    t_int(4'h9, 4'h2, 100);
    ack;
    wait_int(100);
    chk(n + 5, 20);
    ack;
    h.wr(4'h0, 4'h3);
    wait_int(60);
    chk(n, 60);
    h.wr(4'h0, 4'h2);
    wait_int(100);
    chk(n >= 20 && n <= 26, 1);
  endtask
  // Watchdog well past the 22k cycles the run needs
  initial begin
    #200000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_init;
    t_clock;
    t_flag;
    t_codes;
    t_rep;
    end_of_test;
  end
endmodule
